// *** hw/plci_top.sv ***
// Per-port link-change interrupt logic with APB register access
//
// What this block does
// - Link change on port sets sticky bit
// - Writing one clears bit; zero keeps
// - Status one means request pending
// - Mask bit one masks that port
// - Masks at bits 4..0; all reset zero
//
// Notes for the next engineer
// Link levels arrive from the port logic in another domain, so each bit
// passes two flops before anything reads it; only the second flop feeds
// the edge detector, never the first.
// Either edge of a link level counts as a change, so a link that drops
// and comes back inside one check interval sets the bit only once.
// The synchroniser resets to link down: a port that is already up when
// reset ends shows one change a few cycles later. Software that cares
// should clear the status after reset.
// A link change that lands in the same cycle as a write-one clear wins,
// so no change can be lost between a status read and its clear.
// Masking only gates the interrupt line; status bits still set while
// masked, and unmasking a pending bit raises the line at once.
// The bus answers with no wait states: read data is captured in the
// setup cycle and ready rises for exactly the first access cycle.
// Unmapped addresses answer with an error and zero data; writes to them
// are dropped. A write with the low byte strobe off is dropped silently.
// Bits above the port bits read as zero and ignore writes.
//
`timescale 1ns/1ps

module plci_top
  import plci_pkg::*;
(
  input  wire logic                  SYS_CLK,
  input  wire logic                  NRST,
  input  wire logic [PLCI_NPORT-1:0] LINK_UP,
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [PLCI_AW-1:0]    PADDR,
  input  wire logic [PLCI_DW-1:0]    PWDATA,
  input  wire logic [3:0]            PSTRB,
  output logic      [PLCI_DW-1:0]    PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR,
  output logic                       IRQ
);

  logic [PLCI_NPORT-1:0] sync1_reg;
  logic [PLCI_NPORT-1:0] sync2_reg;
  logic [PLCI_NPORT-1:0] link_reg;
  logic [PLCI_NPORT-1:0] link_evt;
  logic [PLCI_NPORT-1:0] status_reg;
  logic [PLCI_NPORT-1:0] status_next;
  logic [PLCI_NPORT-1:0] mask_reg;
  logic [PLCI_NPORT-1:0] mask_next;
  logic [PLCI_DW-1:0]    prdata_reg;
  logic [PLCI_DW-1:0]    prdata_next;
  logic                  pready_reg;
  logic                  pready_next;
  logic                  pslverr_reg;
  logic                  pslverr_next;
  logic                  irq_reg;
  logic                  irq_next;
  logic                  setup_ph;
  logic                  hit_status;
  logic                  hit_mask;
  logic                  wr_ok;
  logic                  wr_status;
  logic                  wr_mask;

  // Two-flop synchroniser and a third stage for edge detection
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      sync1_reg <= PLCI_SYNC_RST;
      sync2_reg <= PLCI_SYNC_RST;
      link_reg  <= PLCI_SYNC_RST;
    end else begin
      sync1_reg <= LINK_UP;
      sync2_reg <= sync1_reg;
      link_reg  <= sync2_reg;
    end
  end

  // Any toggle of a synchronised link level is a link change
  assign link_evt = sync2_reg ^ link_reg;

  // Bus decode; a write lands at the access edge with PREADY high
  assign setup_ph   = PSEL && !PENABLE;
  assign hit_status = (PADDR == PLCI_ADDR_STATUS);
  assign hit_mask   = (PADDR == PLCI_ADDR_MASK);
  assign wr_ok      = PSEL && PENABLE && pready_reg && PWRITE && PSTRB[0];
  assign wr_status  = wr_ok && hit_status;
  assign wr_mask    = wr_ok && hit_mask;

  // Next status and mask; a new event wins over a same-cycle clear
  always_comb begin
    status_next = status_reg;
    mask_next   = mask_reg;
    if (wr_status) begin
      status_next = status_next & ~PWDATA[PLCI_NPORT-1:0];
    end
    status_next = status_next | link_evt;
    if (wr_mask) begin
      mask_next = PWDATA[PLCI_NPORT-1:0];
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      status_reg <= PLCI_STATUS_RST;
      mask_reg   <= PLCI_MASK_RST;
    end else begin
      status_reg <= status_next;
      mask_reg   <= mask_next;
    end
  end

  // Read data, ready and error are prepared in the setup cycle
  always_comb begin
    prdata_next  = prdata_reg;
    pslverr_next = 1'b0;
    pready_next  = setup_ph;
    if (setup_ph) begin
      prdata_next = '0;
      if (hit_status) begin
        prdata_next[PLCI_NPORT-1:0] = status_reg;
      end else if (hit_mask) begin
        prdata_next[PLCI_NPORT-1:0] = mask_reg;
      end else begin
        pslverr_next = 1'b1;
      end
    end
  end

  always_comb begin
    irq_next = |(status_next & ~mask_next);
  end

  // Bus answer and interrupt registers
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      prdata_reg  <= '0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      irq_reg     <= 1'b0;
    end else begin
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      irq_reg     <= irq_next;
    end
  end

  assign PRDATA  = prdata_reg;
  assign PREADY  = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign IRQ     = irq_reg;

  // Checks on the design's own behaviour
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  AST_EVT_SETS: assert property (
    (|link_evt) |=> ((status_reg & $past(link_evt)) == $past(link_evt)))
    else $error("Link change did not set status bit");

  AST_W1C_CLEARS: assert property (
    wr_status |=>
      ((status_reg & $past(PWDATA[PLCI_NPORT-1:0] & ~link_evt)) == '0))
    else $error("Write of one did not clear status bit");

  AST_W0_KEEPS: assert property (
    wr_status |=> ((status_reg & $past(status_reg & ~PWDATA[PLCI_NPORT-1:0]))
                   == $past(status_reg & ~PWDATA[PLCI_NPORT-1:0])))
    else $error("Write of zero changed status bit");

  AST_STATUS_READ: assert property (
    (setup_ph && hit_status) |=>
      (PREADY && !PSLVERR && PRDATA == {27'h0, $past(status_reg)}))
    else $error("Status read returned wrong value");

  AST_MASK_WRITE: assert property (
    wr_mask |=> (mask_reg == $past(PWDATA[PLCI_NPORT-1:0])))
    else $error("Mask write not stored");

  AST_MASK_HOLD: assert property (
    (!wr_mask) |=> $stable(mask_reg))
    else $error("Mask changed without a mask write");

  AST_ALL_MASKED: assert property (
    (&mask_reg) |-> !IRQ)
    else $error("Interrupt raised while every port is masked");

  AST_STICKY: assert property (
    (!wr_status) |=> ((status_reg & $past(status_reg)) == $past(status_reg)))
    else $error("Status bit dropped without a clear");

  AST_NO_SPURIOUS: assert property (
    1'b1 |=> ((status_reg & ~$past(status_reg) & ~$past(link_evt)) == '0))
    else $error("Status bit set without a link change");

  AST_HIGH_ZERO: assert property (
    PRDATA[PLCI_DW-1:PLCI_NPORT] == '0)
    else $error("Read data above the port bits not zero");

  AST_IRQ_FALL: assert property (
    (!(|(status_next & ~mask_next))) |=> !IRQ)
    else $error("Interrupt stayed high with nothing pending");

  // Ready follows the setup cycle
  AST_READY_AFTER_SETUP: assert property (
    setup_ph |=> PREADY)
    else $error("No ready in the first access cycle");

  // Ready only after a setup cycle
  AST_READY_ONLY: assert property (
    (!setup_ph) |=> !PREADY)
    else $error("Ready raised without a setup cycle");

  // Error only with ready
  AST_ERR_WITH_READY: assert property (
    PSLVERR |-> PREADY)
    else $error("Error answer without ready");

  AST_UNMAPPED_WR: assert property (
    (wr_ok && !hit_status && !hit_mask) |=> $stable(mask_reg))
    else $error("Unmapped write changed the mask");

  AST_MASK_READ: assert property (
    (setup_ph && hit_mask) |=> (PRDATA == {27'h0, $past(mask_reg)}))
    else $error("Mask read returned wrong layout");

  AST_IRQ_LEVEL: assert property (
    IRQ == |(status_reg & ~mask_reg))
    else $error("Interrupt output disagrees with status and mask");

  AST_IRQ_RAISE: assert property (
    (|(link_evt & ~mask_next)) |=> IRQ [*1])
    else $error("Unmasked link change did not raise interrupt");

  AST_UNMAPPED: assert property (
    (setup_ph && !hit_status && !hit_mask) |=> (PSLVERR && PRDATA == '0))
    else $error("Unmapped access not answered with error");

  COV_EVT_IRQ:   cover property ((|link_evt) ##1 IRQ);
  COV_CLEAR:     cover property (IRQ ##1 wr_status ##1 !IRQ);
  COV_SET_WINS:  cover property (wr_status && |(link_evt & PWDATA[PLCI_NPORT-1:0]));
  COV_MASKED:    cover property (wr_mask ##1 (|link_evt) ##1 !IRQ);
  COV_ERROR:     cover property (PREADY && PSLVERR);

endmodule // plci_top

// *** include/plci_pkg.sv ***
// Constants for the per-port link-change interrupt block
package plci_pkg;
  localparam int          PLCI_NPORT      = 5;        // Ports one to five
  localparam int          PLCI_AW         = 12;       // APB address width
  localparam int          PLCI_DW         = 32;       // APB data width
  localparam int          PLCI_RW         = 8;        // Register width
  localparam logic [11:0] PLCI_IDX_STATUS = 12'h07c;  // Status register index
  localparam logic [11:0] PLCI_IDX_MASK   = 12'h07d;  // Mask register index
  localparam logic [11:0] PLCI_ADDR_STATUS = 12'(PLCI_IDX_STATUS * 4);
  localparam logic [11:0] PLCI_ADDR_MASK   = 12'(PLCI_IDX_MASK * 4);
  localparam logic [4:0]  PLCI_STATUS_RST = 5'h00;    // Status reset value
  localparam logic [4:0]  PLCI_MASK_RST   = 5'h00;    // Mask reset value
  localparam logic [4:0]  PLCI_SYNC_RST   = 5'h00;    // Link level reset value
endpackage

// *** verification/plci_top_tb_top.sv ***
// Self-checking bench for the link-change interrupt block
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, e); end end

module plci_top_tb_top
  import plci_pkg::*;
;
  logic        sys_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic        pready, pslverr, irq;
  logic [4:0]  link_up = 0, st = 0, mk = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, d;
  logic [32:0] q[$], e_mon;
  int          miscompares = 0, compares = 0, seed = 32'h6672b693;

  always #5 sys_clk = ~sys_clk;

  plci_top u_dut (.SYS_CLK(sys_clk), .NRST(nrst), .LINK_UP(link_up), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq));

  task automatic test_done;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // One APB transfer; a read notes its expected answer
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     input logic [32:0] e);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    if (!w) q.push_back(e);
    @(posedge sys_clk);
    penable <= 1;
    @(posedge sys_clk);
    while (!pready && n < 40) begin
      n++;
      @(posedge sys_clk);
    end
    psel <= 0;
    penable <= 0;
    if (n == 40) begin
      miscompares++;
      $display("MISMATCH %0t no ready from bus", $time);
      test_done();
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [4:0] v);
    apb(0, a, 0, {1'b0, 27'h0, v});
  endtask

  // Interrupt line against the tracked status and mask
  task automatic chk_irq;
    @(posedge sys_clk);
    #1;
    `CHK(irq, |(st & ~mk))
    @(posedge sys_clk);
  endtask

  // Watcher: each completed read is held against the oldest note
  always @(posedge sys_clk) begin
    if (psel && penable && pready && !pwrite) begin
      if (q.size() == 0) begin
        miscompares++;
        $display("MISMATCH %0t read with no expected value", $time);
      end else begin
        e_mon = q.pop_front();
        `CHK({pslverr, prdata}, e_mon)
      end
    end
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1;
    rd(PLCI_ADDR_STATUS, 5'h00);
    rd(PLCI_ADDR_MASK, 5'h00);
    chk_irq();
    $display("reset test done");
    for (int i = 0; i < PLCI_NPORT; i++) begin
      link_up[i] <= ~link_up[i];
      repeat (5) @(posedge sys_clk);
      st[i] = 1'b1;
      rd(PLCI_ADDR_STATUS, st);
      chk_irq();
    end
    $display("link test done");
    d = $random(seed);
    apb(1, PLCI_ADDR_STATUS, d, 0);
    st = st & ~d[4:0];
    rd(PLCI_ADDR_STATUS, st);
    d = $random(seed);
    apb(1, PLCI_ADDR_MASK, d, 0);
    mk = d[4:0];
    rd(PLCI_ADDR_MASK, mk);
    chk_irq();
    // Everything masked: status still sets, line stays low
    apb(1, PLCI_ADDR_MASK, 32'h1f, 0);
    mk = 5'h1f;
    link_up <= ~link_up;
    repeat (5) @(posedge sys_clk);
    st = 5'h1f;
    rd(PLCI_ADDR_STATUS, st);
    chk_irq();
    apb(1, PLCI_ADDR_MASK, 32'h0, 0);
    mk = 5'h00;
    chk_irq();
    $display("mask test done");
    apb(0, 12'h000, 0, {1'b1, 32'h0});
    $display("error test done");
    repeat (3) @(posedge sys_clk);
    test_done();
  end
endmodule // plci_top_tb_top
